// file: hdl/timer_pkg.sv
// Purpose: Constants and types shared by the dual timer/counter block
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Registers are 8 bits wide in the low byte of each word
`default_nettype none
package timer_pkg;
  // ==========================================================================
  // Register indices
  localparam logic [7:0] IDX_TCTRL = 8'h88;
  localparam logic [7:0] IDX_MODE  = 8'h89;
  localparam logic [7:0] IDX_LOW0  = 8'h8A;
  localparam logic [7:0] IDX_LOW1  = 8'h8B;
  localparam logic [7:0] IDX_HIGH0 = 8'h8C;
  localparam logic [7:0] IDX_HIGH1 = 8'h8D;
  localparam logic [7:0] IDX_PRESC = 8'h8E;
  localparam logic [7:0] IDX_ISTAT = 8'h90;
  localparam logic [7:0] IDX_ICLR  = 8'h91;
  localparam logic [7:0] IDX_IEN   = 8'h92;
  localparam int         ADDR_W    = 12;

  // ==========================================================================
  // Field positions
  localparam int TC_OVF1  = 7;
  localparam int TC_RUN1  = 6;
  localparam int TC_OVF0  = 5;
  localparam int TC_RUN0  = 4;
  localparam int TC_XF1   = 3;
  localparam int TC_XT1   = 2;
  localparam int TC_XF0   = 1;
  localparam int TC_XT0   = 0;
  localparam int PS_DIV1  = 4;
  localparam int PS_DIV0  = 3;
  localparam int EV_OVF0  = 0;
  localparam int EV_OVF1  = 1;
  localparam int EV_XF0   = 2;
  localparam int EV_XF1   = 3;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [3:0] EV_RST    = 4'h0;
  localparam logic [3:0] DIV_SLOW  = 4'd12;
  localparam logic [3:0] DIV_FAST  = 4'd4;
  localparam logic [7:0] BYTE_MAX  = 8'hFF;
  localparam logic [4:0] LOW5_MAX  = 5'h1F;

  // ==========================================================================
  // Modes and bus answers
  localparam logic [1:0] MODE_13BIT  = 2'b00;
  localparam logic [1:0] MODE_16BIT  = 2'b01;
  localparam logic [1:0] MODE_RELOAD = 2'b10;
  localparam logic [1:0] MODE_SPLIT  = 2'b11;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       gate;
    logic       count_sel;
    logic [1:0] mode;
  } tmode_s;
endpackage : timer_pkg
`default_nettype wire

// file: hdl/pin_sync.sv
// Purpose: Two-stage synchroniser with falling-edge detect for one pin
// Assumes: Pin is asynchronous to aclk
// Notes:   Falling edge is a one-cycle pulse after the synchronised level
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output var  logic level,
  output var  logic fall
);
  logic meta_r;
  logic prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b1;
      level  <= 1'b1;
      prev_r <= 1'b1;
      fall   <= 1'b0;
    end else begin
      meta_r <= pin;
      level  <= meta_r;
      prev_r <= level;
      fall   <= prev_r & ~level;
    end
  end
endmodule : pin_sync
`default_nettype wire

// file: hdl/dual_timer_counter_ext_irq.sv
// Purpose: Two 16-bit timer/counters with external request detection
// Assumes: Registers reached over AXI4-Lite, one 8-bit register per word
// Notes:   vector_ack pulses clear flags when the CPU enters a handler
// Operation
// [RL1] External flag set by edge/level, cleared on vector
// [RL2] Type bit: set falling edge, clear low level
// [RL3] Gate set: run only while pin high
// [RL4] Counter select counts count-pin falling edges
// [RL5] Mode 0: 13-bit, low five bits prescale
// [RL6] Mode 1: full 16-bit counter
// [RL7] Mode 2: low byte reloads from high byte
// [RL8] Mode 3: timer 0 splits into two bytes
// [RL9] Timer 1 in mode 3 holds its value
// [RL10] Mode register: timer 1 high nibble
// [RL11] Timer 1 clock divides by 12 or 4
// [RL12] Timer 0 clock divides by 12 or 4
// [RL13] Overflow flag set, cleared on vector, writable
// [RL14] Run bit starts and stops each timer
// [RL15] Overflow is wrap; split high byte flags timer 1
// [RL16] Sources hold pin levels for one count clock
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter_ext_irq
  import timer_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  input  wire logic              ext_irq0_pin,
  input  wire logic              ext_irq1_pin,
  input  wire logic              timer0_count_pin,
  input  wire logic              timer1_count_pin,
  input  wire logic [3:0]        vector_ack,
  output var  logic [3:0]        req_flags,
  output var  logic              irq
);
  // ==========================================================================
  // State
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_full_r;
  logic [7:0]        w_data_r;
  logic              w_strb_r;
  logic              w_full_r;
  logic [1:0]        ovf_flag_r;
  logic [1:0]        run_r;
  logic [1:0]        ext_flag_r;
  logic [1:0]        ext_type_r;
  tmode_s [1:0]      tmode_r;
  logic [7:0]        lo0_r;
  logic [7:0]        hi0_r;
  logic [7:0]        lo1_r;
  logic [7:0]        hi1_r;
  logic [1:0]        div_sel_r;
  logic [3:0]        istat_r;
  logic [3:0]        ien_r;
  logic [3:0]        lvl;
  logic [3:0]        fall;
  logic [1:0]        tick;
  logic [1:0]        inc;
  logic              hi0_inc;
  logic [16:0]       step0;
  logic [16:0]       step1;
  logic [1:0]        ev_ovf;
  logic [1:0]        ev_ext;
  logic              wr_go;
  logic              wr_hit;
  logic              wr_en;
  logic [7:0]        wr_idx;
  logic [7:0]        wdat;
  logic              rd_hit;
  logic [7:0]        rd_val;

  // ==========================================================================
  // Pin synchronisers: ext0, ext1, count0, count1
  logic [3:0] pins;
  assign pins = {timer1_count_pin, timer0_count_pin, ext_irq1_pin,
                 ext_irq0_pin};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    pin_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (pins[i]),
      .level   (lvl[i]),
      .fall    (fall[i])
    );
  end

  // ==========================================================================
  // Prescalers
  for (genvar i = 0; i < 2; i++) begin : g_div
    logic [3:0] lim;
    logic [3:0] cnt_r;
    assign lim     = div_sel_r[i] ? DIV_FAST : DIV_SLOW;        // [RL11] [RL12]
    assign tick[i] = cnt_r >= lim - 4'd1;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_r <= 4'd0;
      end else if (tick[i]) begin
        cnt_r <= 4'd0;
      end else begin
        cnt_r <= cnt_r + 4'd1;
      end
    end
  end

  // ==========================================================================
  // Counting
  function automatic logic [16:0] step(input logic [1:0] md,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    unique case (md)
      MODE_13BIT: begin                                          // [RL5]
        if (lo[4:0] == LOW5_MAX) begin
          r = {hi == BYTE_MAX, hi + 8'h01, lo[7:5], 5'h00};
        end else begin
          r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
        end
      end
      MODE_16BIT:  r = {1'b0, hi, lo} + 17'h0_0001;             // [RL6]
      MODE_RELOAD: begin                                         // [RL7]
        if (lo == BYTE_MAX) begin
          r = {1'b1, hi, hi};
        end else begin
          r = {1'b0, hi, lo + 8'h01};
        end
      end
      MODE_SPLIT:  r = {lo == BYTE_MAX, hi, lo + 8'h01};        // [RL8]
    endcase
    return r;
  endfunction : step

  always_comb begin
    inc[0] = run_r[0] & (~tmode_r[0].gate | lvl[0])              // [RL3] [RL14]
           & (tmode_r[0].count_sel ? fall[2] : tick[0]);         // [RL4]
    inc[1] = run_r[1] & (~tmode_r[1].gate | lvl[1])              // [RL3] [RL14]
           & (tmode_r[1].count_sel ? fall[3] : tick[1])          // [RL4]
           & (tmode_r[1].mode != MODE_SPLIT);                    // [RL9]
    hi0_inc = (tmode_r[0].mode == MODE_SPLIT) & run_r[1] & tick[0]; // [RL8]
    step0 = step(tmode_r[0].mode, lo0_r, hi0_r);
    step1 = step(tmode_r[1].mode, lo1_r, hi1_r);
    ev_ovf[0] = inc[0] & step0[16];                              // [RL15]
    if (tmode_r[0].mode == MODE_SPLIT) begin
      ev_ovf[1] = hi0_inc & (hi0_r == BYTE_MAX);                 // [RL15]
    end else begin
      ev_ovf[1] = inc[1] & step1[16];
    end
    ev_ext[0] = ext_type_r[0] ? fall[0] : (~lvl[0] & ~ext_flag_r[0]);
    ev_ext[1] = ext_type_r[1] ? fall[1] : (~lvl[1] & ~ext_flag_r[1]);
  end

  // ==========================================================================
  // Register write decode
  assign wr_idx = aw_addr_r[9:2];
  assign wdat   = w_data_r;
  assign wr_go  = aw_full_r & w_full_r & ~bvalid;
  assign wr_hit = (aw_addr_r[ADDR_W-1:10] == '0)
                & (((wr_idx >= IDX_TCTRL) & (wr_idx <= IDX_PRESC))
                 | ((wr_idx >= IDX_ISTAT) & (wr_idx <= IDX_IEN)));
  assign wr_en  = wr_go & wr_hit & w_strb_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmode_r   <= REG_RST;
      div_sel_r <= 2'b00;
      ien_r     <= EV_RST;
    end else if (wr_en) begin
      if (wr_idx == IDX_MODE) begin
        tmode_r <= wdat;                                         // [RL10]
      end
      if (wr_idx == IDX_PRESC) begin
        div_sel_r <= {wdat[PS_DIV1], wdat[PS_DIV0]};             // [RL11] [RL12]
      end
      if (wr_idx == IDX_IEN) begin
        ien_r <= wdat[3:0];
      end
    end
  end

  // Software writes win over counting in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo0_r <= REG_RST;
      hi0_r <= REG_RST;
      lo1_r <= REG_RST;
      hi1_r <= REG_RST;
    end else begin
      if (wr_en && wr_idx == IDX_LOW0) begin
        lo0_r <= wdat;
      end else if (inc[0]) begin
        lo0_r <= step0[7:0];
      end
      if (wr_en && wr_idx == IDX_HIGH0) begin
        hi0_r <= wdat;
      end else if (hi0_inc) begin
        hi0_r <= hi0_r + 8'h01;                                  // [RL8]
      end else if (inc[0]) begin
        hi0_r <= step0[15:8];
      end
      if (wr_en && wr_idx == IDX_LOW1) begin
        lo1_r <= wdat;
      end else if (inc[1]) begin
        lo1_r <= step1[7:0];
      end
      if (wr_en && wr_idx == IDX_HIGH1) begin
        hi1_r <= wdat;
      end else if (inc[1]) begin
        hi1_r <= step1[15:8];
      end
    end
  end

  // ==========================================================================
  // Control flags; hardware set beats software or vector clear
  logic tc_wr;
  assign tc_wr = wr_en & (wr_idx == IDX_TCTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag_r <= 2'b00;
      run_r      <= 2'b00;
      ext_flag_r <= 2'b00;
      ext_type_r <= 2'b00;
    end else begin
      if (tc_wr) begin
        run_r      <= {wdat[TC_RUN1], wdat[TC_RUN0]};           // [RL14]
        ext_type_r <= {wdat[TC_XT1], wdat[TC_XT0]};             // [RL2]
        ovf_flag_r <= {wdat[TC_OVF1], wdat[TC_OVF0]} | ev_ovf;  // [RL13]
      end else begin
        ovf_flag_r <= (ovf_flag_r & ~vector_ack[1:0]) | ev_ovf; // [RL13]
      end
      for (int i = 0; i < 2; i++) begin
        if (!ext_type_r[i]) begin
          ext_flag_r[i] <= ~lvl[i];                              // [RL1]
        end else if (tc_wr) begin
          ext_flag_r[i] <= wdat[TC_XF0 + 2*i] | fall[i];         // [RL1]
        end else begin
          ext_flag_r[i] <= (ext_flag_r[i] & ~vector_ack[2+i])
                         | fall[i];                              // [RL1] [RL2]
        end
      end
    end
  end

  assign req_flags = {ext_flag_r[1], ext_flag_r[0], ovf_flag_r[1],
                      ovf_flag_r[0]};

  // ==========================================================================
  // Interrupt status, clear and enable
  logic [3:0] iclr;
  assign iclr = (wr_en && wr_idx == IDX_ICLR) ? wdat[3:0] : EV_RST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= EV_RST;
      irq     <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~iclr) | {ev_ext, ev_ovf};
      irq     <= |(istat_r & ien_r);
    end
  end

  // ==========================================================================
  // AXI4-Lite write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awready   <= 1'b1;
      aw_addr_r <= '0;
      w_full_r  <= 1'b0;
      wready    <= 1'b1;
      w_data_r  <= REG_RST;
      w_strb_r  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        awready   <= 1'b0;
        aw_addr_r <= awaddr;
      end else if (bvalid && bready) begin
        aw_full_r <= 1'b0;
        awready   <= 1'b1;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        wready   <= 1'b0;
        w_data_r <= wdata[7:0];
        w_strb_r <= wstrb[0];
      end else if (bvalid && bready) begin
        w_full_r <= 1'b0;
        wready   <= 1'b1;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channels
  always_comb begin
    rd_hit = araddr[ADDR_W-1:10] == '0;
    rd_val = REG_RST;
    unique case (araddr[9:2])
      IDX_TCTRL: rd_val = {ovf_flag_r[1], run_r[1], ovf_flag_r[0], run_r[0],
                           ext_flag_r[1], ext_type_r[1], ext_flag_r[0],
                           ext_type_r[0]};
      IDX_MODE:  rd_val = tmode_r;
      IDX_LOW0:  rd_val = lo0_r;
      IDX_LOW1:  rd_val = lo1_r;
      IDX_HIGH0: rd_val = hi0_r;
      IDX_HIGH1: rd_val = hi1_r;
      IDX_PRESC: rd_val = {3'b000, div_sel_r, 3'b000};
      IDX_ISTAT: rd_val = {4'h0, istat_r};
      IDX_ICLR:  rd_val = REG_RST;
      IDX_IEN:   rd_val = {4'h0, ien_r};
      default:   rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_hit ? rd_val : REG_RST};
      rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_gap_fast;
    div_sel_r[1] [*4];
  endsequence
  sequence s_gap_slow;
    !div_sel_r[0] [*8] ##1 !div_sel_r[0] [*4];
  endsequence

  property p_ext_level;
    $past(!ext_type_r[0]) |-> ext_flag_r[0] == !$past(lvl[0]);
  endproperty
  a_ext_level: assert property (p_ext_level) // [RL1]
    else $error("level-mode request flag does not follow inverted pin");

  property p_ext_edge;
    ext_type_r[1] && fall[1] |=> ext_flag_r[1];
  endproperty
  a_ext_edge: assert property (p_ext_edge) // [RL2]
    else $error("falling edge did not set request flag");

  property p_gate;
    tmode_r[0].gate && !lvl[0] && !wr_en |=> $stable(lo0_r);
  endproperty
  a_gate: assert property (p_gate) // [RL3]
    else $error("gated timer advanced while pin low");

  property p_count_pin;
    tmode_r[0].count_sel && !fall[2] && !wr_en |=> $stable(lo0_r);
  endproperty
  a_count_pin: assert property (p_count_pin) // [RL4]
    else $error("counter advanced without a count pin edge");

  property p_mode13;
    tmode_r[0].mode == MODE_13BIT && inc[0] && lo0_r[4:0] == LOW5_MAX
      && !wr_en |=> lo0_r[4:0] == 5'h00 && hi0_r == $past(hi0_r) + 8'h01;
  endproperty
  a_mode13: assert property (p_mode13) // [RL5]
    else $error("13-bit mode carry into high byte wrong");

  property p_mode16;
    tmode_r[1].mode == MODE_16BIT && inc[1] && lo1_r == BYTE_MAX
      && !wr_en |=> lo1_r == 8'h00 && hi1_r == $past(hi1_r) + 8'h01;
  endproperty
  a_mode16: assert property (p_mode16) // [RL6]
    else $error("16-bit mode carry wrong");

  property p_reload;
    tmode_r[0].mode == MODE_RELOAD && inc[0] && lo0_r == BYTE_MAX
      && !wr_en |=> lo0_r == $past(hi0_r) && ovf_flag_r[0];
  endproperty
  a_reload: assert property (p_reload) // [RL7]
    else $error("auto-reload or overflow flag missing");

  property p_split;
    hi0_inc && hi0_r == BYTE_MAX |=> ovf_flag_r[1];
  endproperty
  a_split: assert property (p_split) // [RL8]
    else $error("split high byte overflow did not flag timer 1");

  property p_t1_hold;
    tmode_r[1].mode == MODE_SPLIT && !wr_en |=> $stable({hi1_r, lo1_r});
  endproperty
  a_t1_hold: assert property (p_t1_hold) // [RL9]
    else $error("timer 1 moved in mode 3");

  property p_div_fast;
    tick[1] ##1 s_gap_fast |-> tick[1] && $past(!tick[1], 1);
  endproperty
  a_div_fast: assert property (p_div_fast) // [RL11]
    else $error("divide-by-4 tick spacing wrong");

  property p_div_slow;
    tick[0] ##1 s_gap_slow |-> tick[0];
  endproperty
  a_div_slow: assert property (p_div_slow) // [RL12]
    else $error("divide-by-12 tick spacing wrong");

  property p_ovf_ack;
    ev_ovf[0] && vector_ack[0] |=> ovf_flag_r[0];
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) // [RL13]
    else $error("overflow lost against vector clear");

  property p_run;
    !run_r[0] && tmode_r[0].mode != MODE_SPLIT && !wr_en
      |=> $stable({hi0_r, lo0_r});
  endproperty
  a_run: assert property (p_run) // [RL14]
    else $error("stopped timer advanced");

  property p_irq;
    |(istat_r & ien_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled status did not raise interrupt");
endmodule : dual_timer_counter_ext_irq
`default_nettype wire

// file: bench/pin_source.sv
// Purpose: Model of the sources on the request and count pins
// Assumes: Pins idle high, as with a pull-up on each line
// Notes:   Each level is held longer than the slowest count tick
`timescale 1ns/10ps
`default_nettype none
module pin_source #(
  parameter int HOLD = 13
) (
  input  wire logic       aclk,
  output var  logic [3:0] pins
);
  initial pins = 4'hF;

  // ==========================================================================
  // Level and pulse drivers
  task automatic level(input int which, input logic v);
    @(posedge aclk);
    pins[which] <= v;
    repeat (HOLD) @(posedge aclk);
  endtask : level

  task automatic pulse(input int which, input int n);
    for (int i = 0; i < n; i++) begin
      level(which, 1'b0);
      level(which, 1'b1);
    end
  endtask : pulse
endmodule : pin_source
`default_nettype wire

// file: bench/tb_dual_timer_counter_ext_irq.sv
// Purpose: Self-checking bench for the dual timer/counter block
// Assumes: Pins come from pin_source; registers over AXI4-Lite
// Notes:   Timed windows allow one prescaler tick of slack at divide-by-12, two at divide-by-4
`timescale 1ns/10ps
`default_nettype none
module tb_dual_timer_counter_ext_irq
  import timer_pkg::*;
;
  localparam int LIMIT = 20000;
  localparam logic [7:0] RIDX [7] = '{IDX_TCTRL, IDX_MODE, IDX_LOW0, IDX_LOW1,
                                      IDX_HIGH0, IDX_HIGH1, IDX_PRESC};
  logic              aclk, aresetn, awvalid, awready, wvalid, wready;
  logic              bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rdv;
  logic [3:0]        wstrb, vector_ack, req_flags, pins;
  logic [1:0]        bresp, rresp, resp_q;
  int                mismatches, compares, cycles, lo, hi;

  always #2 aclk = ~aclk;

  dual_timer_counter_ext_irq i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_irq0_pin(pins[0]), .ext_irq1_pin(pins[1]),
    .timer0_count_pin(pins[2]), .timer1_count_pin(pins[3]),
    .vector_ack(vector_ack), .req_flags(req_flags), .irq(irq));

  pin_source i_src (.aclk(aclk), .pins(pins));

  // ==========================================================================
  // Checking and closing
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================================
  // Bus master
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp_q = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdv = rdata;
    resp_q = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    rd(idx);
    chk(rdv, {24'h00_0000, e});
  endtask : rchk

  task automatic cnt_case(input logic [3:0] nib, input logic run,
                          input logic [7:0] tl, th, input int n,
                          input logic [7:0] etl, eth, input logic eovf);
    wr(IDX_MODE, {4'h0, nib});
    wr(IDX_LOW0, tl);
    wr(IDX_HIGH0, th);
    wr(IDX_TCTRL, {3'b000, run, 4'h0});
    i_src.pulse(2, n);
    chk(req_flags[EV_OVF0], eovf);
    wr(IDX_TCTRL, 8'h00);
    rchk(IDX_LOW0, etl);
    rchk(IDX_HIGH0, eth);
  endtask : cnt_case

  // ==========================================================================
  // Main sequence
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = '0; araddr = '0; wdata = '0;
    wstrb = 4'hF; vector_ack = 4'h0; mismatches = 0; compares = 0;
    cycles = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (RIDX[i]) rchk(RIDX[i], REG_RST);
    wr(8'h87, 8'h5A);
    chk(resp_q, RESP_SLVERR);
    rd(8'h87);
    chk(rdv, 32'h0000_0000);
    chk(resp_q, RESP_SLVERR);
    wr(IDX_MODE, 8'hA5);
    rchk(IDX_MODE, 8'hA5);
    wr(IDX_MODE, 8'h11);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_PRESC, k[1] ? 8'h18 : 8'h00);
      wr(k[0] ? IDX_LOW1 : IDX_LOW0, 8'h00);
      wr(IDX_TCTRL, k[0] ? 8'h40 : 8'h10);
      repeat (240) @(posedge aclk);
      wr(IDX_TCTRL, 8'h00);
      rd(k[0] ? IDX_LOW1 : IDX_LOW0);
      lo = k[1] ? 60 : 20;
      hi = k[1] ? 62 : 21;
      if (rdv >= lo && rdv <= hi) chk(rdv, rdv);
      else chk(rdv, lo);
    end
    cnt_case(4'h4, 1, 8'hFE, 8'hFF, 2, 8'hE0, 8'h00, 1);
    cnt_case(4'h5, 1, 8'hFF, 8'h12, 1, 8'h00, 8'h13, 0);
    cnt_case(4'h6, 1, 8'hFF, 8'h80, 2, 8'h81, 8'h80, 1);
    cnt_case(4'h5, 0, 8'h05, 8'h00, 2, 8'h05, 8'h00, 0);
    rchk(IDX_ISTAT, 8'h01);
    chk(irq, 1'b0);
    wr(IDX_IEN, 8'h01);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(IDX_ICLR, 8'h01);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rchk(IDX_ICLR, 8'h00);
    wr(IDX_TCTRL, 8'h20);
    repeat (2) @(posedge aclk);
    chk(req_flags[EV_OVF0], 1'b1);
    vector_ack <= 4'h1;
    @(posedge aclk);
    vector_ack <= 4'h0;
    repeat (2) @(posedge aclk);
    chk(req_flags[EV_OVF0], 1'b0);
    i_src.level(0, 1'b0);
    cnt_case(4'hD, 1, 8'h05, 8'h00, 2, 8'h05, 8'h00, 0);
    chk(req_flags[EV_XF0], 1'b1);
    i_src.level(0, 1'b1);
    cnt_case(4'hD, 1, 8'h05, 8'h00, 2, 8'h07, 8'h00, 0);
    for (int x = 0; x < 2; x++) begin
      wr(IDX_TCTRL, x ? 8'h04 : 8'h01);
      i_src.pulse(x, 1);
      chk(req_flags[EV_XF0 + x], 1'b1);
      vector_ack <= 4'h4 << x;
      @(posedge aclk);
      vector_ack <= 4'h0;
      repeat (2) @(posedge aclk);
      chk(req_flags[EV_XF0 + x], 1'b0);
      wr(IDX_TCTRL, 8'h00);
      i_src.level(x, 1'b0);
      chk(req_flags[EV_XF0 + x], 1'b1);
      i_src.level(x, 1'b1);
      chk(req_flags[EV_XF0 + x], 1'b0);
    end
    wr(IDX_MODE, 8'h77);
    wr(IDX_LOW0, 8'h10);
    wr(IDX_LOW1, 8'h33);
    wr(IDX_HIGH0, 8'hF0);
    wr(IDX_TCTRL, 8'h50);
    i_src.pulse(2, 1);
    i_src.pulse(3, 2);
    chk(req_flags[EV_OVF1], 1'b1);
    wr(IDX_TCTRL, 8'h00);
    rchk(IDX_LOW0, 8'h11);
    rchk(IDX_LOW1, 8'h33);
    results();
  end
endmodule : tb_dual_timer_counter_ext_irq
`default_nettype wire
